// file: design/holdover_freq_select.sv
// Contract
// (R1) Averaging disabled: holdover uses the manual value or an instantly frozen value.
// (R2) Averaging enabled: holdover uses the averaged frequency unless manual is engaged.
// (R3) Rate select bit: 0 chooses slow average, 1 chooses fast average.
// (R4) Readback bit 0: manual frequency word reads back what software wrote.
// (R5) Readback bit 1: manual word reads the fast or slow averaged frequency.
// (R6) Mini source 00 follows full holdover choice; 01 freezes instantly.
// (R7) Mini source 10 takes the fast average; 11 takes the slow average.
// (R8) Mode control register is read/write at 0x40, resetting to 0x88.
// (R9) Bits 15 to 8 of the manual word sit in their own register.
// (R10) Control bits 2 to 0 hold bits 18 to 16 of the manual word.
// (R11) Temporary input loss while locked enters mini-holdover with its own source.
module holdover_freq_select #(
  parameter int freq_width = 19
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic holdover_active,
  input wire logic locked,
  input wire logic input_lost,
  input wire logic manual_engaged,
  input wire logic [freq_width-1:0] current_freq,
  input wire logic [freq_width-1:0] fast_average,
  input wire logic [freq_width-1:0] slow_average,
  output logic averaging_fast,
  output logic mini_holdover,
  output logic [3:0] freq_source,
  output logic [freq_width-1:0] holdover_freq
);

  // Registers reachable from the register port. The mode register carries the
  // control fields and the top three bits of the manual word.
  logic [7:0] mode_control;
  logic [7:0] freq_low;
  logic [7:0] freq_mid;
  // Write strobes, one for each register, decoded from the address.
  logic write_mode;
  logic write_mid;
  logic write_low;
  // Control fields pulled out of the mode register by name.
  logic auto_averaging;
  logic read_average;
  logic [1:0] mini_mode;
  // Frequency words handled inside the block.
  logic [freq_width-1:0] manual_freq;
  logic [freq_width-1:0] selected_average;
  logic [freq_width-1:0] frozen_freq;
  logic [freq_width-1:0] frozen_value;
  logic [freq_width-1:0] readback_word;
  logic [freq_width-1:0] next_holdover_freq;
  // Hold state in this cycle and on the previous edge.
  logic in_hold;
  logic in_hold_d;
  logic mini_only;
  // Source picked by the full holdover rules, then after the mini-holdover override.
  holdover_freq_select_pkg::freq_source_e full_source;
  holdover_freq_select_pkg::freq_source_e next_source;

  // Write address decode. At most one strobe is high in a cycle, and a write
  // to any address outside the three registers leaves every register alone.
  always_comb begin
    write_mode = 1'b0;
    write_mid = 1'b0;
    write_low = 1'b0;
    if (reg_write) begin
      if (reg_addr == holdover_freq_select_pkg::addr_mode_control) begin
        write_mode = 1'b1; // [R8]
      end else if (reg_addr == holdover_freq_select_pkg::addr_freq_mid) begin
        write_mid = 1'b1; // [R9]
      end else if (reg_addr == holdover_freq_select_pkg::addr_freq_low) begin
        write_low = 1'b1; // [R4]
      end
    end
  end

  // Mode control register. After reset, averaging is on at the slow rate,
  // readback shows the written word and mini-holdover freezes instantly.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_control <= holdover_freq_select_pkg::mode_control_reset; // [R8]
    end else if (write_mode) begin
      mode_control <= reg_wdata; // [R8]
    end
  end

  // Middle byte of the manual word, bits 15 to 8.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      freq_mid <= holdover_freq_select_pkg::freq_byte_reset;
    end else if (write_mid) begin
      freq_mid <= reg_wdata; // [R9]
    end
  end

  // Low byte of the manual word, bits 7 to 0.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      freq_low <= holdover_freq_select_pkg::freq_byte_reset;
    end else if (write_low) begin
      freq_low <= reg_wdata; // [R4]
    end
  end

  // Control fields. The rate bit is also an output, so the loop's averager
  // runs at the rate that software chose.
  assign auto_averaging = mode_control[holdover_freq_select_pkg::bit_auto_averaging]; // [R1] [R2]
  assign averaging_fast = mode_control[holdover_freq_select_pkg::bit_fast_averaging]; // [R3]
  assign read_average = mode_control[holdover_freq_select_pkg::bit_read_average]; // [R4] [R5]
  assign mini_mode = mode_control[holdover_freq_select_pkg::mini_mode_hi:
                                  holdover_freq_select_pkg::mini_mode_lo]; // [R6] [R7]

  // Manual word. Its top three bits sit in the mode register and its middle
  // and low bytes in their own registers. Software writes the bytes one at a
  // time, so the word is only whole once the last of them has landed.
  assign manual_freq = freq_width'({mode_control[holdover_freq_select_pkg::freq_top_hi:0],
                                    freq_mid, freq_low}); // [R9] [R10]

  // Averaged frequency at the chosen rate, used only by readback; holdover picks the fast or slow average itself.
  assign selected_average = averaging_fast ? fast_average : slow_average; // [R3] [R5]

  // Mini-holdover is a short loss of input while locked. It only steers the
  // source while full holdover is off, since full holdover has its own choice.
  assign mini_holdover = locked && input_lost; // [R11]
  assign mini_only = mini_holdover && !holdover_active; // [R11]
  assign in_hold = holdover_active || mini_holdover;

  // Hold history. A low value marks a cycle on which the frozen register still
  // loads, and that includes the first cycle of a hold.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_hold_d <= 1'b0;
    end else begin
      in_hold_d <= in_hold;
    end
  end

  // Frozen frequency. It follows the input until the first cycle of a hold,
  // takes the input on that edge and then keeps it until the hold ends. Both
  // hold states share it, so a mini-holdover that grows into full holdover
  // keeps the value caught at the start of the loss.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      frozen_freq <= '0;
    end else if (!in_hold_d) begin
      frozen_freq <= current_freq; // [R1] [R6]
    end
  end

  // On the first hold cycle the register is still loading, so the live input is
  // handed on; it is the very value that the register keeps from then on.
  assign frozen_value = in_hold_d ? frozen_freq : current_freq; // [R1] [R6]

  // Full holdover source first: manual beats averaging, averaging beats the
  // frozen value. The mini-holdover field then overrides it while only a short
  // loss is in progress.
  always_comb begin
    if (manual_engaged) begin
      full_source = holdover_freq_select_pkg::src_manual; // [R1] [R2]
    end else if (auto_averaging) begin
      if (averaging_fast) begin
        full_source = holdover_freq_select_pkg::src_fast; // [R2] [R3]
      end else begin
        full_source = holdover_freq_select_pkg::src_slow; // [R2] [R3]
      end
    end else begin
      full_source = holdover_freq_select_pkg::src_frozen; // [R1]
    end
    next_source = full_source;
    if (mini_only) begin
      case (mini_mode)
        holdover_freq_select_pkg::mini_as_full: begin
          next_source = full_source; // [R6] [R11]
        end
        holdover_freq_select_pkg::mini_frozen: begin
          next_source = holdover_freq_select_pkg::src_frozen; // [R6]
        end
        holdover_freq_select_pkg::mini_fast: begin
          next_source = holdover_freq_select_pkg::src_fast; // [R7]
        end
        default: begin
          next_source = holdover_freq_select_pkg::src_slow; // [R7]
        end
      endcase
    end
  end

  // Frequency that goes with the chosen source.
  always_comb begin
    case (next_source)
      holdover_freq_select_pkg::src_manual: begin
        next_holdover_freq = manual_freq; // [R1] [R2]
      end
      holdover_freq_select_pkg::src_frozen: begin
        next_holdover_freq = frozen_value; // [R1] [R6]
      end
      holdover_freq_select_pkg::src_fast: begin
        next_holdover_freq = fast_average; // [R2] [R7]
      end
      default: begin
        next_holdover_freq = slow_average; // [R2] [R7]
      end
    endcase
  end

  // Source code handed to the loop, registered so that it changes only on a
  // clock edge and stays one-hot throughout.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      freq_source <= holdover_freq_select_pkg::src_manual;
    end else begin
      freq_source <= next_source; // [R11]
    end
  end

  // Holdover frequency handed to the loop, registered beside its source code
  // so that the two always change on the same edge.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      holdover_freq <= '0;
    end else begin
      holdover_freq <= next_holdover_freq; // [R1] [R2]
    end
  end

  // Readback word for the manual frequency registers. With the readback bit
  // set, software sees the averager's output in place of what it wrote.
  assign readback_word = read_average ? selected_average : manual_freq; // [R4] [R5]

  // Read mux. Reads have no side effects, and unmapped addresses read zero.
  always_comb begin
    if (reg_addr == holdover_freq_select_pkg::addr_freq_low) begin
      reg_rdata = readback_word[7:0]; // [R4] [R5]
    end else if (reg_addr == holdover_freq_select_pkg::addr_freq_mid) begin
      reg_rdata = readback_word[15:8]; // [R5] [R9]
    end else if (reg_addr == holdover_freq_select_pkg::addr_mode_control) begin
      reg_rdata = mode_control; // [R8]
      if (read_average) begin
        reg_rdata[2:0] = readback_word[18:16]; // [R5] [R10]
      end
    end else begin
      reg_rdata = 8'h00;
    end
  end

endmodule : holdover_freq_select

// file: inc/holdover_freq_select_pkg.sv
package holdover_freq_select_pkg;
  // Register addresses on the device register port.
  localparam logic [7:0] addr_freq_low = 8'h3e;
  localparam logic [7:0] addr_freq_mid = 8'h3f;
  localparam logic [7:0] addr_mode_control = 8'h40;
  // Values after reset.
  localparam logic [7:0] mode_control_reset = 8'h88;
  localparam logic [7:0] freq_byte_reset = 8'h00;
  // Field positions inside the mode control register.
  localparam int bit_auto_averaging = 7;
  localparam int bit_fast_averaging = 6;
  localparam int bit_read_average = 5;
  localparam int mini_mode_hi = 4;
  localparam int mini_mode_lo = 3;
  localparam int freq_top_hi = 2;
  // Mini-holdover source codes.
  localparam logic [1:0] mini_as_full = 2'h0;
  localparam logic [1:0] mini_frozen = 2'h1;
  localparam logic [1:0] mini_fast = 2'h2;
  localparam logic [1:0] mini_slow = 2'h3;
  // Source of the frequency applied to the main timing loop.
  typedef enum logic [3:0] {
    src_manual = 4'b0001,
    src_frozen = 4'b0010,
    src_fast = 4'b0100,
    src_slow = 4'b1000
  } freq_source_e;
endpackage : holdover_freq_select_pkg

// file: verification/holdover_freq_select_checker.sv
module holdover_freq_select_checker #(
  parameter int freq_width = 19
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic locked,
  input wire logic input_lost,
  input wire logic [freq_width-1:0] fast_average,
  input wire logic [freq_width-1:0] slow_average,
  input wire logic averaging_fast,
  input wire logic mini_holdover,
  input wire logic [3:0] freq_source,
  input wire logic [freq_width-1:0] holdover_freq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mode_copy;
  // Copy of the mode register, rebuilt from the writes seen on the port.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_copy <= 8'h88;
    end else if (reg_write && reg_addr == 8'h40) begin
      mode_copy <= reg_wdata;
    end
  end
  // Every check samples on the system clock and rests while reset is low.
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  AST_MINI: assert property (mini_holdover == (locked && input_lost))
    else $error("mini flag wrong");
  AST_RATE: assert property ((reg_write && reg_addr == 8'h40) |=>
    averaging_fast == $past(reg_wdata[6])) else $error("rate bit wrong");
  AST_ONEHOT: assert property ($onehot(freq_source)) else $error("source not one-hot");
  AST_FAST: assert property ((freq_source == 4'b0100) |->
    holdover_freq == $past(fast_average)) else $error("fast value wrong");
  AST_SLOW: assert property ((freq_source == 4'b1000) |->
    holdover_freq == $past(slow_average)) else $error("slow value wrong");
  AST_WRBACK: assert property ((reg_addr == 8'h40 && !mode_copy[5]) |->
    reg_rdata == mode_copy) else $error("readback wrong");
  AST_UNMAP: assert property ((reg_addr > 8'h40 || reg_addr < 8'h3e) |->
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_AVG_RD: assert property ((reg_addr == 8'h3e && mode_copy[5]) |->
    reg_rdata == (mode_copy[6] ? fast_average[7:0] : slow_average[7:0]))
    else $error("average read wrong");
endmodule : holdover_freq_select_checker

// file: verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, reset_n = 1'b0, reg_write = 1'b0, sel = 1'b0, look = 1'b0;
  logic holdover_active = 1'b0, locked = 1'b0, input_lost = 1'b0, manual_engaged = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [18:0] current_freq = 19'h00000, fast_average = 19'h00000, slow_average = 19'h00000;
  logic [18:0] holdover_freq;
  logic [3:0] freq_source;
  logic averaging_fast, mini_holdover;
  logic [22:0] exp_q[$];
  logic [31:0] seed = 32'hfd02;
  int num_errors = 0, compares = 0;
  holdover_freq_select u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .holdover_active(holdover_active), .locked(locked), .input_lost(input_lost),
    .manual_engaged(manual_engaged), .current_freq(current_freq), .fast_average(fast_average),
    .slow_average(slow_average), .averaging_fast(averaging_fast),
    .mini_holdover(mini_holdover), .freq_source(freq_source), .holdover_freq(holdover_freq));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic check(input logic [22:0] seen, input logic [22:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic complete_run();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr
  // Notes an expectation; sel picks the read port or the frequency path.
  task automatic note(input logic s, input logic [7:0] a, input logic [22:0] e);
    @(posedge clk_sys);
    sel <= s;
    reg_addr <= a;
    look <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    look <= 1'b0;
  endtask : note
  // Free-running system clock.
  initial forever #12.5 clk_sys = ~clk_sys;
  // Takes the oldest note whenever the driver marks a result cycle.
  always @(negedge clk_sys) begin
    if (look) begin
      check(sel ? {15'h0000, reg_rdata} : {freq_source, holdover_freq},
            exp_q.pop_front());
    end
  end
  // Cuts a hung run short.
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    complete_run();
  end
  // Main sequence: reset, registers, holdover sources, mini-holdover codes, readback.
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    note(1, 8'h40, 23'h88);
    note(1, 8'h3f, 23'h00);
    note(1, 8'h41, 23'h00);
    seed = lfsr(lfsr(seed));
    fast_average <= seed[18:0];
    slow_average <= seed[26:8];
    current_freq <= seed[31:13];
    @(posedge clk_sys);
    holdover_active <= 1'b1;
    note(0, 8'h00, {4'h8, slow_average});
    wr(8'h40, 8'hc8);
    note(0, 8'h00, {4'h4, fast_average});
    wr(8'h3e, 8'h5a);
    wr(8'h3f, 8'ha5);
    wr(8'h40, 8'hcd);
    manual_engaged <= 1'b1;
    note(0, 8'h00, {4'h1, 19'h5a55a});
    note(1, 8'h3e, 23'h5a);
    wr(8'h40, 8'h0d);
    note(0, 8'h00, {4'h1, 19'h5a55a});
    manual_engaged <= 1'b0;
    current_freq <= ~current_freq;
    note(0, 8'h00, {4'h2, current_freq});
    holdover_active <= 1'b0;
    locked <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      input_lost <= 1'b0;
      wr(8'h40, {3'b100, 2'(c), 3'b000});
      input_lost <= 1'b1;
      note(0, 8'h00, c == 1 ? {4'h2, current_freq} :
           c == 2 ? {4'h4, fast_average} : {4'h8, slow_average});
      // The frozen mini-holdover value must not follow a later input change.
      if (c == 1) begin
        current_freq <= ~current_freq;
        note(0, 8'h00, {4'h2, current_freq});
      end
    end
    wr(8'h40, 8'h60);
    note(1, 8'h3e, {15'h0000, fast_average[7:0]});
    wr(8'h40, 8'h20);
    note(1, 8'h3f, {15'h0000, slow_average[15:8]});
    complete_run();
  end
endmodule : tb_top
bind holdover_freq_select holdover_freq_select_checker #(.freq_width(freq_width)) u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .locked(locked), .input_lost(input_lost),
  .fast_average(fast_average), .slow_average(slow_average), .averaging_fast(averaging_fast),
  .mini_holdover(mini_holdover), .freq_source(freq_source), .holdover_freq(holdover_freq));
